/* File: core/scm_modem_pins.sv */
// Purpose: modem control and handshake pin logic of one serial channel
// Assumes: pins asynchronous to clk_i, engines on clk_i
// Notes:   registers reached over classic Wishbone
// How it works
// - auto enables: clear-to-send low gates transmitter
// - auto off: clear-to-send is plain input
// - clear-to-send edges flagged both directions
// - auto enables: carrier-detect low enables receiver
// - carrier-detect edges flagged both directions
// - async auto: request-to-send rises after transmitter empty
// - auto off: request-to-send pin inverts control bit
// - sdlc enhancement: drop request after closing flag
// - async receive: sync pin only updates hunt status
// - external sync: assembly starts at preceding edge
// - internal sync: output pulse for match phase
// - sdlc: sync output valid on received flag
// - sync pin output in mono, bi, sdlc modes
// - select bit chooses terminal-ready or dma request
// - enhancement bit picks request release timing
// - wait pin open drain, request driven, wait reset
// - wait stalls cpu, request feeds dma
// - clock pin routable to four clock users
// - crystal option pairs clock and sync pins
// - async receive clock factor 1, 16, 32, 64
// - everything synchronised to master clock
//
// The Wishbone slave port and the address map were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

module scm_modem_pins
  import scm_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // modem pins
  input  wire logic        clear_to_send_n_i,
  input  wire logic        carrier_detect_n_i,
  input  wire logic        rx_tx_clock_pin_n_i,
  input  wire logic        sync_n_i,
  output logic             sync_n_o,
  output logic             sync_oe_n_o,
  output logic             request_to_send_n_o,
  output logic             term_ready_req_n_o,
  output logic             wait_req_n_o,
  output logic             wait_req_oe_n_o,
  // engine side
  input  wire logic        tx_empty_i,
  input  wire logic        closing_flag_done_i,
  input  wire logic        sync_match_i,
  input  wire logic        flag_rx_i,
  input  wire logic        tx_dma_req_i,
  input  wire logic        cpu_wait_i,
  output logic             tx_enable_o,
  output logic             rx_enable_o,
  output logic             assembly_start_o,
  output logic             rx_sample_o,
  output logic             ext_event_o,
  output scm_route_s       clk_route_o
);

  // ****************************************************************
  // registers and bus slave
  // ****************************************************************
  logic [7:0]  rx_ctrl, mode_sel, tx_ctrl, enh_ctrl, misc_ctrl;
  logic [7:0]  evt_en, wreq_ctrl;
  logic [4:0]  route;
  logic [2:0]  chg;          // sticky change flags: cts, sync, dcd
  logic [2:0]  edge_now;     // edges seen this cycle
  logic        wr_stb;
  logic        rts_hw_clr;
  logic [31:0] next_dat;
  scm_pins_s   meta, pins, pins_d;
  scm_sync_role_e sync_role;
  scm_rts_e    rts_st;

  // writes land at the edge where the master sees ack high
  assign wr_stb = cyc_i && stb_i && we_i && ack_o && sel_i[0];

  // single-wait-state answer, ack drops after one cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= cyc_i && stb_i && !ack_o;
    end
  end

  // control register writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_ctrl   <= RST_REG8;
      mode_sel  <= RST_REG8;
      enh_ctrl  <= RST_REG8;
      misc_ctrl <= RST_REG8;
      evt_en    <= RST_REG8;
      wreq_ctrl <= RST_REG8; // wait mode after reset
      route     <= 5'h00;
    end else if (wr_stb) begin
      unique case (adr_i)
        ADDR_RX_CTRL:   rx_ctrl   <= dat_i[7:0];
        ADDR_MODE:      mode_sel  <= dat_i[7:0];
        ADDR_ENH:       enh_ctrl  <= dat_i[7:0];
        ADDR_MISC:      misc_ctrl <= dat_i[7:0];
        ADDR_EVT_EN:    evt_en    <= dat_i[7:0];
        ADDR_WREQ:      wreq_ctrl <= dat_i[7:0];
        ADDR_CLK_ROUTE: route     <= dat_i[4:0];
        default: ;
      endcase
    end
  end

  // transmit control, request bit also cleared by hardware
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_ctrl <= RST_REG8;
    end else if (wr_stb && adr_i == ADDR_TX_CTRL) begin
      tx_ctrl <= dat_i[7:0];
    end else if (rts_hw_clr) begin
      tx_ctrl[RTS_BIT] <= 1'b0;
    end
  end

  // read mux, unmapped reads as zero
  always_comb begin
    next_dat = 32'h0000_0000;
    unique case (adr_i)
      ADDR_RX_CTRL:   next_dat[7:0] = rx_ctrl;
      ADDR_MODE:      next_dat[7:0] = mode_sel;
      ADDR_TX_CTRL:   next_dat[7:0] = tx_ctrl;
      ADDR_ENH:       next_dat[7:0] = enh_ctrl;
      ADDR_MISC:      next_dat[7:0] = misc_ctrl;
      ADDR_EVT_EN:    next_dat[7:0] = evt_en;
      ADDR_WREQ:      next_dat[7:0] = wreq_ctrl;
      ADDR_CLK_ROUTE: next_dat[4:0] = route;
      ADDR_STATUS: begin
        next_dat[ST_TXE_BIT]  = tx_empty_i;
        next_dat[ST_DCD_BIT]  = !pins.dcd;
        next_dat[ST_SYNC_BIT] = !pins.sync;
        next_dat[ST_CTS_BIT]  = !pins.cts;
        next_dat[CHG_DCD_BIT]  = chg[0];
        next_dat[CHG_SYNC_BIT] = chg[1];
        next_dat[CHG_CTS_BIT]  = chg[2];
      end
      default: ;
    endcase
  end

  // read data registered with ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
    end else if (cyc_i && stb_i && !ack_o && !we_i) begin
      dat_o <= next_dat;
    end
  end

  // ****************************************************************
  // input synchronisers and edge detection
  // ****************************************************************
  // two-stage synchroniser, reset to idle levels so no false edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta   <= PINS_IDLE;
      pins   <= PINS_IDLE;
      pins_d <= PINS_IDLE;
    end else begin
      meta   <= {clear_to_send_n_i, carrier_detect_n_i, sync_n_i,
                 !rx_tx_clock_pin_n_i};
      pins   <= meta;
      pins_d <= pins;
    end
  end

  logic rxc_rise, rxc_fall, sync_hunt_en;
  assign rxc_rise = pins.rxc && !pins_d.rxc;
  assign rxc_fall = !pins.rxc && pins_d.rxc;
  // sync input only counts when not an output or crystal
  assign sync_hunt_en = (sync_role == SR_INPUT);

  // both directions of cts and dcd flagged, sync only while the pin is an input
  always_comb begin
    edge_now[2] = pins.cts ^ pins_d.cts;
    edge_now[1] = (pins.sync ^ pins_d.sync) && sync_hunt_en;
    edge_now[0] = pins.dcd ^ pins_d.dcd;
  end

  // sticky change flags, set wins over write-one clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chg <= 3'h0;
    end else begin
      if (wr_stb && adr_i == ADDR_STATUS) begin
        chg <= (chg & ~{dat_i[CHG_CTS_BIT], dat_i[CHG_SYNC_BIT],
                        dat_i[CHG_DCD_BIT]}) | edge_now;
      end else begin
        chg <= chg | edge_now;
      end
    end
  end

  // enabled edge events for the channel interrupt logic
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ext_event_o <= 1'b0;
    end else begin
      ext_event_o <= |(edge_now & {evt_en[ST_CTS_BIT], evt_en[ST_SYNC_BIT],
                                   evt_en[ST_DCD_BIT]});
    end
  end

  // ****************************************************************
  // auto enables
  // ****************************************************************
  logic auto_en;
  assign auto_en = rx_ctrl[AUTO_EN_BIT];

  // transmitter gated by clear-to-send when auto on
  // receiver gated by carrier-detect when auto on
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_enable_o <= 1'b0;
      rx_enable_o <= 1'b0;
    end else begin
      tx_enable_o <= tx_ctrl[TX_EN_BIT] && !(auto_en && pins.cts);
      rx_enable_o <= rx_ctrl[RX_EN_BIT] && !(auto_en && pins.dcd);
    end
  end

  // ****************************************************************
  // request-to-send
  // ****************************************************************
  logic is_async, is_sdlc;
  assign is_async = (mode_sel[3:2] != STOP_SYNC);
  assign is_sdlc  = !is_async && (mode_sel[5:4] == SM_SDLC);

  // closing flag gone: request bit cleared
  assign rts_hw_clr = is_sdlc && enh_ctrl[ENH_RTS_BIT] && closing_flag_done_i;

  // drain state keeps request active until empty
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rts_st <= RTS_IDLE;
    end else begin
      unique case (rts_st)
        RTS_IDLE:  if (tx_ctrl[RTS_BIT]) rts_st <= RTS_ON;
        RTS_ON:    if (!tx_ctrl[RTS_BIT]) begin
          rts_st <= (auto_en && is_async && !tx_empty_i) ? RTS_DRAIN
                                                         : RTS_IDLE;
        end
        RTS_DRAIN: begin
          if (tx_ctrl[RTS_BIT]) rts_st <= RTS_ON;
          else if (tx_empty_i || !auto_en) rts_st <= RTS_IDLE;
        end
      endcase
    end
  end

  // manual mode: pin is inverse of the bit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      request_to_send_n_o <= 1'b1;
    end else if (!auto_en) begin
      request_to_send_n_o <= !tx_ctrl[RTS_BIT];
    end else begin
      // on-to-drain step keeps the pin low, no one-cycle release
      request_to_send_n_o <= !(tx_ctrl[RTS_BIT] || rts_st == RTS_DRAIN
                               || (rts_st == RTS_ON && is_async
                                   && !tx_empty_i));
    end
  end

  // ****************************************************************
  // sync pin
  // ****************************************************************
  logic sync_pulse, sync_ext, ext_armed;
  assign sync_ext = !is_async && (mode_sel[5:4] == SM_EXT);

  // pin role from mode and crystal option
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_role <= SR_INPUT;
    end else if (route[XTAL_BIT]) begin
      sync_role <= SR_XTAL;
    end else if (!is_async && !sync_ext) begin
      sync_role <= SR_OUTPUT;
    end else begin
      sync_role <= SR_INPUT;
    end
  end

  // active from match until the clock phase ends
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_pulse <= 1'b0;
    end else if (sync_match_i || (is_sdlc && flag_rx_i)) begin
      sync_pulse <= 1'b1;
    end else if (rxc_fall || rxc_rise) begin
      sync_pulse <= 1'b0;
    end
  end

  // pin drive: output enable low only while driving
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_oe_n_o <= 1'b1;
      sync_n_o    <= 1'b1;
    end else begin
      sync_oe_n_o <= (sync_role != SR_OUTPUT);
      sync_n_o    <= !sync_pulse;
    end
  end

  // partner holds sync low two receive clocks
  // armed by each receive clock rise, fires on sync activation
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ext_armed        <= 1'b0;
      assembly_start_o <= 1'b0;
    end else begin
      assembly_start_o <= 1'b0;
      if (rxc_rise) begin
        ext_armed <= 1'b1;
      end
      if (sync_ext && sync_hunt_en && ext_armed && !pins.sync
          && pins_d.sync) begin
        assembly_start_o <= 1'b1;
        ext_armed        <= rxc_rise;
      end
    end
  end

  // ****************************************************************
  // clock routing and clock factor
  // ****************************************************************
  // routing selects straight from the register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clk_route_o <= '0;
    end else begin
      clk_route_o <= scm_route_s'(route);
    end
  end

  // one sample per factor receive clock edges
  logic [5:0] fact_lim, fact_cnt;
  always_comb begin
    unique case (mode_sel[7:6])
      2'h0: fact_lim = FACT_1;
      2'h1: fact_lim = FACT_16;
      2'h2: fact_lim = FACT_32;
      2'h3: fact_lim = FACT_64;
    endcase
    if (!is_async) fact_lim = FACT_1;
  end

  // divider counts sampled edges on the master clock
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fact_cnt    <= 6'h00;
      rx_sample_o <= 1'b0;
    end else begin
      rx_sample_o <= 1'b0;
      if (rxc_rise) begin
        if (fact_cnt >= fact_lim) begin
          fact_cnt    <= 6'h00;
          rx_sample_o <= 1'b1;
        end else begin
          fact_cnt <= fact_cnt + 6'h01;
        end
      end
    end
  end

  // ****************************************************************
  // terminal-ready/request and wait/request
  // ****************************************************************
  logic [3:0] rel_cnt;
  logic       legacy_req;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rel_cnt <= 4'h0;
    end else if (tx_dma_req_i) begin
      rel_cnt <= LEGACY_REL_CYC;
    end else if (rel_cnt != 4'h0) begin
      rel_cnt <= rel_cnt - 4'h1;
    end
  end
  assign legacy_req = tx_dma_req_i || (rel_cnt != 4'h0);

  // select bit picks terminal-ready or dma request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      term_ready_req_n_o <= 1'b1;
    end else if (!misc_ctrl[DMA_SEL_BIT]) begin
      term_ready_req_n_o <= !tx_ctrl[DTR_BIT];
    end else if (enh_ctrl[ENH_DTR_BIT]) begin
      term_ready_req_n_o <= !tx_dma_req_i;
    end else begin
      term_ready_req_n_o <= !legacy_req;
    end
  end

  // wait pulls low open drain, request drives both
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wait_req_n_o    <= 1'b0;
      wait_req_oe_n_o <= 1'b1;
    end else if (!wreq_ctrl[WREQ_EN_BIT]) begin
      wait_req_n_o    <= 1'b0;
      wait_req_oe_n_o <= 1'b1;
    end else if (wreq_ctrl[WREQ_REQ_BIT]) begin
      wait_req_n_o    <= !tx_dma_req_i;
      wait_req_oe_n_o <= 1'b0;
    end else begin
      wait_req_n_o    <= 1'b0;
      wait_req_oe_n_o <= !cpu_wait_i;
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_cts_gates_tx: assert property (
    (auto_en && pins.cts) |=> !tx_enable_o)
    else $error("transmitter enabled while clear-to-send high");

  a_dcd_gates_rx: assert property (
    (auto_en && pins.dcd) |=> !rx_enable_o)
    else $error("receiver enabled while carrier-detect high");

  a_rts_manual: assert property (
    !auto_en |=> request_to_send_n_o == !$past(tx_ctrl[RTS_BIT]))
    else $error("request-to-send not inverse of bit");

  a_rts_drain: assert property (
    (rts_st == RTS_DRAIN && !tx_empty_i && auto_en) |=>
      !request_to_send_n_o)
    else $error("request-to-send released before empty");

  a_cts_edge_flag: assert property (
    (pins.cts != pins_d.cts) |=> chg[2])
    else $error("clear-to-send edge not flagged");

  a_sync_drive: assert property (
    (sync_role == SR_OUTPUT) |=> !sync_oe_n_o)
    else $error("sync pin not driven in output role");

  a_dtr_follow: assert property (
    !misc_ctrl[DMA_SEL_BIT] |=>
      term_ready_req_n_o == !$past(tx_ctrl[DTR_BIT]))
    else $error("terminal-ready pin not following bit");

  a_legacy_hold: assert property (
    (misc_ctrl[DMA_SEL_BIT] && !enh_ctrl[ENH_DTR_BIT] && tx_dma_req_i)
      ##1 (misc_ctrl[DMA_SEL_BIT] && !enh_ctrl[ENH_DTR_BIT]) [*3]
      |=> !term_ready_req_n_o)
    else $error("legacy release came too early");

  a_wait_reset: assert property (
    $fell(rst_i) |-> !wreq_ctrl[WREQ_REQ_BIT])
    else $error("wait/request not in wait mode after reset");

  a_ack_once: assert property (
    ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");

endmodule : scm_modem_pins

`default_nettype wire

/* File: core/scm_pkg.sv */
// Purpose: constants, types and register map of the modem pin logic
// Assumes: 32-bit classic Wishbone, byte offsets, 8-bit control registers, status change flags in bits 10:8
// Notes:   one serial channel per instance

// ****************************************************************
// package
// ****************************************************************
package scm_pkg;

  // register byte offsets
  localparam logic [7:0] ADDR_RX_CTRL   = 8'h00; // receive_control_reg
  localparam logic [7:0] ADDR_MODE      = 8'h04; // mode_select_reg
  localparam logic [7:0] ADDR_TX_CTRL   = 8'h08; // transmit_control_reg
  localparam logic [7:0] ADDR_ENH       = 8'h0c; // enhancement_control_reg
  localparam logic [7:0] ADDR_MISC      = 8'h10; // misc_control_reg
  localparam logic [7:0] ADDR_STATUS    = 8'h14; // line_status_reg
  localparam logic [7:0] ADDR_CLK_ROUTE = 8'h18;
  localparam logic [7:0] ADDR_EVT_EN    = 8'h1c;
  localparam logic [7:0] ADDR_WREQ      = 8'h20;

  // field positions
  localparam int RX_EN_BIT     = 0;
  localparam int AUTO_EN_BIT   = 5;
  localparam int TX_EN_BIT     = 3;
  localparam int RTS_BIT       = 1;
  localparam int DTR_BIT       = 7;
  localparam int ENH_RTS_BIT   = 2;
  localparam int ENH_DTR_BIT   = 4;
  localparam int DMA_SEL_BIT   = 2;
  localparam int XTAL_BIT      = 4;
  localparam int ST_DCD_BIT    = 3;
  localparam int ST_SYNC_BIT   = 4;
  localparam int ST_CTS_BIT    = 5;
  localparam int ST_TXE_BIT    = 2;
  localparam int CHG_DCD_BIT   = 8;
  localparam int CHG_SYNC_BIT  = 9;
  localparam int CHG_CTS_BIT   = 10;
  localparam int WREQ_EN_BIT   = 0;
  localparam int WREQ_REQ_BIT  = 1;

  // reset values
  localparam logic [7:0] RST_REG8 = 8'h00;

  // mode_select_reg fields: stop bits [3:2], sync mode [5:4], factor [7:6]
  localparam logic [1:0] STOP_SYNC = 2'h0;
  localparam logic [1:0] SM_MONO   = 2'h0;
  localparam logic [1:0] SM_BI     = 2'h1;
  localparam logic [1:0] SM_SDLC   = 2'h2;
  localparam logic [1:0] SM_EXT    = 2'h3;

  // receive clock factors x1, x16, x32, x64 (edges per bit minus one)
  localparam logic [5:0] FACT_1  = 6'h00;
  localparam logic [5:0] FACT_16 = 6'h0f;
  localparam logic [5:0] FACT_32 = 6'h1f;
  localparam logic [5:0] FACT_64 = 6'h3f;

  // legacy release of the terminal-ready/request pin
  localparam int         CLK_NS          = 50;
  localparam int         LEGACY_REL_NS   = 200;
  localparam logic [3:0] LEGACY_REL_CYC  = 4'(LEGACY_REL_NS / CLK_NS);

  typedef enum logic [1:0] {RTS_IDLE, RTS_ON, RTS_DRAIN} scm_rts_e;
  typedef enum logic [1:0] {SR_INPUT, SR_OUTPUT, SR_XTAL} scm_sync_role_e;

  // synchronised modem inputs, high = pin high (inactive), except rxc: high = clock pin low
  typedef struct packed {
    logic cts;
    logic dcd;
    logic sync;
    logic rxc;
  } scm_pins_s;

  // idle pin levels: modem inputs high, receive clock low
  localparam scm_pins_s PINS_IDLE = '{cts: 1'b1, dcd: 1'b1, sync: 1'b1,
                                      rxc: 1'b0};

  // clock routing of the receive/transmit clock pin
  typedef struct packed {
    logic xtal;
    logic pll;
    logic baud;
    logic tx;
    logic rx;
  } scm_route_s;

endpackage : scm_pkg

/* File: sim/scm_line_partner.sv */
// Purpose: line-side model: receive clock and sync line
// Assumes: sync line has a pull-up when nobody pulls it low
// Notes:   receive clock rises when rxc_n_o falls
`timescale 1ns/100ps
`default_nettype none

// ********************
// line partner
// ********************
module scm_line_partner (
  input  wire logic dev_sync_n_i,
  input  wire logic dev_sync_oe_n_i,
  output logic      rxc_n_o,
  output wire logic sync_n_o
);
  bit   run;          // receive clock runs while set
  logic drive_sync_n; // partner pull on the sync line

  // wired sync line: pull-up, either party may pull low
  assign sync_n_o = drive_sync_n & (dev_sync_oe_n_i | dev_sync_n_i);

  // 400 ns receive clock, parks high when stopped, off clk phase
  initial begin
    rxc_n_o = 1'b1;
    drive_sync_n = 1'b1;
    #7;
    forever begin
      #200;
      if (run || !rxc_n_o) rxc_n_o = ~rxc_n_o;
    end
  end

  task automatic ext_sync();
    @(negedge rxc_n_o);
    drive_sync_n = 1'b0;
    repeat (2) @(negedge rxc_n_o);
    drive_sync_n = 1'b1;
  endtask : ext_sync
endmodule : scm_line_partner
`default_nettype wire

/* File: sim/scm_modem_pins_test.sv */
// Purpose: self-checking bench of the modem pin logic
// Assumes: one-cycle bus answer, three-edge pin latency
// Notes:   pulse counters sample on the falling clock edge
`timescale 1ns/100ps
`default_nettype none

`define CHK(got, exp, msg) \
  begin \
    comparisons++; \
    if ((got) !== (exp)) begin \
      fail_count++; \
      $display("mismatch at %0t: %s", $time, msg); \
    end \
  end

// ********************
// bench top
// ********************
module scm_modem_pins_test
  import scm_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        cyc, stb, we, ack;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] dat, q, rdat;
  logic        cts_n, dcd_n, tx_empty, dma_req, cpu_wait;
  logic [2:0]  pls;
  wire logic   rxc_n, sync_n;
  logic        sync_q, sync_oe_n, rts_n, trq_n, wrq_n, wrq_oe_n;
  logic        tx_en, rx_en, asm_st, rx_smp, ext_evt;
  scm_route_s  route;
  logic [1:0]  mds [3] = '{SM_SDLC, SM_MONO, SM_BI};
  int          fail_count, comparisons, cycles, n_evt, n_asm, n_smp, n0;

  scm_modem_pins dut (
    .clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(rdat), .ack_o(ack),
    .clear_to_send_n_i(cts_n), .carrier_detect_n_i(dcd_n),
    .rx_tx_clock_pin_n_i(rxc_n), .sync_n_i(sync_n), .sync_n_o(sync_q),
    .sync_oe_n_o(sync_oe_n), .request_to_send_n_o(rts_n),
    .term_ready_req_n_o(trq_n), .wait_req_n_o(wrq_n),
    .wait_req_oe_n_o(wrq_oe_n), .tx_empty_i(tx_empty),
    .closing_flag_done_i(pls[0]), .sync_match_i(pls[1]),
    .flag_rx_i(pls[2]), .tx_dma_req_i(dma_req), .cpu_wait_i(cpu_wait),
    .tx_enable_o(tx_en), .rx_enable_o(rx_en), .assembly_start_o(asm_st),
    .rx_sample_o(rx_smp), .ext_event_o(ext_evt), .clk_route_o(route)
  );

  scm_line_partner line (
    .dev_sync_n_i(sync_q), .dev_sync_oe_n_i(sync_oe_n),
    .rxc_n_o(rxc_n), .sync_n_o(sync_n)
  );

  // 20 MHz master clock
  always #25 clk = ~clk;

  // pulse counters and watchdog, mid-cycle to avoid races
  always @(negedge clk) begin
    cycles++;
    if (ext_evt === 1'b1) n_evt++;
    if (asm_st === 1'b1) n_asm++;
    if (rx_smp === 1'b1) n_smp++;
    if (cycles == 10000) begin
      fail_count++;
      final_report();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  // one classic bus cycle, held until ack
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hf;
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask : wb

  // one-cycle engine pulse
  task automatic pulse(input int k);
    pls[k] <= 1'b1;
    @(posedge clk);
    pls[k] <= 1'b0;
  endtask : pulse

  task automatic done(input string s);
    $display("test %s done, %0d mismatches", s, fail_count);
  endtask : done

  task automatic final_report();
    $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : final_report

  // main sequence
  initial begin
    {cyc, stb, we, adr, sel, dat} = '0;
    {cts_n, dcd_n} = 2'h3;
    {tx_empty, dma_req, cpu_wait, pls} = '0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    `CHK(rts_n, 1'b1, "rts reset")
    `CHK({wrq_n, wrq_oe_n}, 2'h1, "wait reset")
    wb(1, ADDR_RX_CTRL, 32'h01);
    wb(1, ADDR_TX_CTRL, 32'h8a);
    tick(1);
    `CHK(rts_n, 1'b0, "rts manual")
    `CHK(trq_n, 1'b0, "dtr on")
    `CHK(tx_en, 1'b1, "cts ignored")
    `CHK(rx_en, 1'b1, "dcd ignored")
    wb(1, ADDR_TX_CTRL, 32'h08);
    tick(1);
    `CHK({rts_n, trq_n}, 2'h3, "rts dtr off")
    wb(1, 8'h40, 32'hff);
    wb(0, 8'h40, 32'h0);
    `CHK(q, 32'h0, "unmapped read")
    done("manual");
    wb(1, ADDR_EVT_EN, 32'h28);
    wb(1, ADDR_RX_CTRL, 32'h21);
    tick(4);
    `CHK({tx_en, rx_en}, 2'h0, "auto pins high")
    n0 = n_evt;
    cts_n <= 1'b0;
    tick(6);
    dcd_n <= 1'b0;
    tick(6);
    `CHK(tx_en, 1'b1, "cts enables tx")
    `CHK(rx_en, 1'b1, "dcd enables rx")
    `CHK(n_evt - n0, 2, "two events")
    wb(0, ADDR_STATUS, 32'h0);
    `CHK(q & 32'h528, 32'h528, "status flags")
    wb(1, ADDR_STATUS, 32'h700);
    cts_n <= 1'b1;
    tick(6);
    wb(0, ADDR_STATUS, 32'h0);
    `CHK(q & 32'h520, 32'h400, "cts rise flagged")
    done("auto");
    wb(1, ADDR_MODE, 32'h04);
    cts_n <= 1'b0;
    wb(1, ADDR_TX_CTRL, 32'h0a);
    tick(4);
    `CHK(rts_n, 1'b0, "rts on auto")
    wb(1, ADDR_TX_CTRL, 32'h08);
    tick(1);
    `CHK(rts_n, 1'b0, "rts no early release")
    tick(3);
    `CHK(rts_n, 1'b0, "rts held till empty")
    tx_empty <= 1'b1;
    tick(3);
    `CHK(rts_n, 1'b1, "rts off when empty")
    `CHK(sync_oe_n, 1'b1, "sync input async")
    n0 = n_asm;
    line.drive_sync_n <= 1'b0;
    tick(6);
    wb(0, ADDR_STATUS, 32'h0);
    `CHK(q & 32'h210, 32'h210, "sync hunt status")
    `CHK(n_asm - n0, 0, "no assembly async")
    line.drive_sync_n <= 1'b1;
    done("async");
    tx_empty <= 1'b0;
    wb(1, ADDR_MODE, 32'h20);
    wb(1, ADDR_ENH, 32'h04);
    wb(1, ADDR_TX_CTRL, 32'h0a);
    tick(2);
    `CHK(rts_n, 1'b0, "rts sdlc on")
    pulse(0);
    tick(2);
    `CHK(rts_n, 1'b1, "rts off after flag")
    wb(0, ADDR_TX_CTRL, 32'h0);
    `CHK(q, 32'h08, "rts bit cleared")
    for (int i = 0; i < 3; i++) begin
      wb(1, ADDR_MODE, {26'h0, mds[i], 4'h0});
      tick(2);
      `CHK(sync_oe_n, 1'b0, "sync pin output")
      pulse(i == 0 ? 2 : 1);
      tick(2);
      `CHK(sync_q, 1'b0, "sync out active")
      line.run = 1'b1;
      tick(20);
      line.run = 1'b0;
      tick(8);
      `CHK(sync_q, 1'b1, "sync out ends")
    end
    wb(1, ADDR_MODE, {26'h0, SM_EXT, 4'h0});
    tick(2);
    `CHK(sync_oe_n, 1'b1, "ext sync input")
    n0 = n_asm;
    line.run = 1'b1;
    line.ext_sync();
    tick(8);
    `CHK(n_asm - n0, 1, "assembly start once")
    done("sync");
    for (int i = 0; i < 4; i++) begin
      wb(1, ADDR_MODE, {24'h0, 2'(i), 6'h04});
      @(negedge rxc_n);
      tick(5);
      n0 = n_smp;
      repeat (64) @(negedge rxc_n);
      tick(5);
      `CHK(n_smp - n0, 64 >> (i == 0 ? 0 : i + 3), "factor")
    end
    line.run = 1'b0;
    done("factor");
    wb(1, ADDR_MISC, 32'h04);
    for (int i = 0; i < 2; i++) begin
      wb(1, ADDR_ENH, i ? 32'h10 : 32'h0);
      dma_req <= 1'b1;
      tick(3);
      `CHK(trq_n, 1'b0, "dma request on")
      dma_req <= 1'b0;
      tick(2);
      `CHK(trq_n, 1'(i), "release timing")
      tick(int'(LEGACY_REL_CYC) + 2);
      `CHK(trq_n, 1'b1, "request released")
    end
    wb(1, ADDR_WREQ, 32'h01);
    cpu_wait <= 1'b1;
    tick(2);
    `CHK({wrq_oe_n, wrq_n}, 2'h0, "wait pulls low")
    cpu_wait <= 1'b0;
    tick(2);
    `CHK(wrq_oe_n, 1'b1, "wait released")
    wb(1, ADDR_WREQ, 32'h03);
    dma_req <= 1'b1;
    tick(2);
    `CHK({wrq_oe_n, wrq_n}, 2'h0, "request active")
    dma_req <= 1'b0;
    tick(2);
    `CHK({wrq_oe_n, wrq_n}, 2'h1, "request driven high")
    done("request");
    for (int i = 0; i < 5; i++) begin
      wb(1, ADDR_CLK_ROUTE, 32'(1 << i));
      tick(1);
      `CHK(route, 5'(1 << i), "clock route")
    end
    wb(1, ADDR_MODE, 32'h20);
    tick(2);
    `CHK(sync_oe_n, 1'b1, "crystal frees sync")
    done("route");
    final_report();
  end
endmodule : scm_modem_pins_test
`default_nettype wire
